/* File: core/interprocessor_dma_link_regs.sv */
// Purpose: Registers and cycle control of one end of a half-duplex DMA link.
// Assumes: Single 200 MHz clock; peer link inputs synchronous to it.
// Notes: Data words pass through a FIFO between local bus and link.
// Functional notes
// - Counter counts up; overflow sets ready.
// - Pointer bit zero always zero.
// - Missing memory sets error; cleared with it.
// - Peer alert pulse sets error while present.
// - Pointer wrap sets error until reload.
// - Error sets ready, may interrupt.
// - No slave reply in 20 us: missing memory.
// - Missing memory clears on zero write, reset.
// - Bit 13 shows live peer alert.
// - Diagnostic bit read/write, reset clears.
// - Bit 11 mirrors peer request; ready, interrupt.
// - Bit 10 mirrors peer direction.
// - Bit 9 mirrors peer mode.
// - Cycle plus start: immediate local cycle.
// - Peer cycle request sets cycle; launch clears.
// - Ready blocks DMA cycles and mastership.
// - Irq allow gates error, ready, request.
// - Bits 5,4 give address bits 17,16.
// - Bit 3 sent as peer request.
// - Mode bit only displayed to peer.
// - Start reads zero, clears ready, signals.
// - Read then write cycles alternate pairs.
`timescale 1ns/100ps
`default_nettype none
module interprocessor_dma_link_regs
	import link_regs_pkg::*;
#(
	parameter int TIMEOUT_CYC = NEX_TIMEOUT_CYC,
	parameter int FIFO_DEPTH = 16
) (
	// Clock and system clear.
	input wire logic clk,
	input wire logic rst_n,
	// Local register port.
	input wire link_regs_pkg::reg_req_type reg_req,
	output logic [15:0] reg_rdata,
	// Link to the companion.
	input wire link_regs_pkg::link_type peer_in,
	output link_regs_pkg::link_type peer_out,
	// Local bus master.
	output logic bus_msync,
	output logic bus_write,
	output logic [17:0] bus_addr,
	input wire logic bus_ssync,
	input wire logic [15:0] bus_rdata,
	output logic [15:0] bus_wdata,
	output logic irq,
	// Link data words.
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [15:0] tx_data,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [15:0] rx_data
);
	import link_regs_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_XFER = 3'b010,
		ST_DONE = 3'b100
	} dma_state_type;

	// Refuse a timeout that cannot be counted.
	if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 65535) begin : g_bad_timeout
		$error("TIMEOUT_CYC must lie between 1 and 65535.");
	end

	dma_state_type state_q;
	logic [15:0] count_q;
	logic [15:0] ptr_q;
	logic [15:0] tmo_q;
	logic nex_q, wrap_q, diag_q, cycle_q, ready_q, allow_q;
	logic ext_hi_q, ext_lo_q, req_out_q, dir_q, mode_q;
	logic go_cycle_q, go_peer_q, end_q;
	logic wr_st, wr_cnt, wr_ptr, start, launch, done, timeout;
	logic error;
	logic rx_fifo_valid;
	logic [15:0] rx_fifo_data;
	logic tx_fifo_ready;
	logic req_seen_q;
	logic [16:0] age_q;

	// Decoded register writes.
	assign wr_st = reg_req.wr && reg_req.sel == SEL_STATUS;
	assign wr_cnt = reg_req.wr && reg_req.sel == SEL_COUNTER;
	assign wr_ptr = reg_req.wr && reg_req.sel == SEL_POINTER;
	assign start = wr_st && reg_req.wdata[BIT_START];

	// join missing memory into the error flag.
	assign error = nex_q || peer_in.alert || wrap_q;

	// cycle gating
	// A cycle begins only from idle while ready is clear.
	// paired cycles: transmitter reads, receiver writes, each on its own request.
	assign launch = state_q == ST_IDLE && !ready_q && cycle_q
		&& (dir_q ? rx_fifo_valid : tx_fifo_ready);
	assign done = state_q == ST_XFER && bus_ssync;
	assign timeout = state_q == ST_XFER && !bus_ssync && tmo_q == 16'(TIMEOUT_CYC - 1);

	// Bus cycle sequencer.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (launch) begin
						state_q <= ST_XFER;
					end
				end
				ST_XFER: begin
					if (done || timeout) begin
						state_q <= ST_DONE;
					end
				end
				ST_DONE: begin
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// reply timer
	// Counts cycles of master sync without a slave reply.
	always_ff @(posedge clk) begin
		if (!rst_n || state_q != ST_XFER) begin
			tmo_q <= WORD_RESET;
		end else begin
			tmo_q <= tmo_q + 16'h0001;
		end
	end

	// Bus outputs; direction one makes this end the receiver that writes.
	assign bus_msync = state_q == ST_XFER;
	assign bus_write = dir_q;
	assign bus_addr = {ext_hi_q, ext_lo_q, ptr_q};
	assign bus_wdata = rx_fifo_data;

	// word counter
	// Software loads a negative count; each answered cycle steps it toward zero.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_q <= WORD_RESET;
		end else if (wr_cnt) begin
			count_q <= reg_req.wdata;
		end else if (done) begin
			count_q <= count_q + 16'h0001;
		end
	end

	// wrap detect: the carry out of the top bit marks the wrap.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ptr_q <= WORD_RESET;
			wrap_q <= 1'b0;
		end else if (wr_ptr) begin
			ptr_q <= {reg_req.wdata[15:1], 1'b0};
			// A wrap in the same cycle as a reload still sets the flag.
			wrap_q <= done && ptr_q[15:1] == 15'h7fff;
		end else if (done) begin
			ptr_q <= ptr_q + POINTER_STEP;
			if (ptr_q[15:1] == 15'h7fff) begin
				wrap_q <= 1'b1;
			end
		end
	end

	// set on timeout; a set in the same cycle as a clear wins.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			nex_q <= 1'b0;
		end else if (timeout) begin
			nex_q <= 1'b1;
		end else if (wr_st && !reg_req.wdata[BIT_NEX]) begin
			nex_q <= 1'b0;
		end
	end

	// error, peer request and overflow set ready; start clears it.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ready_q <= 1'b1;
		end else if (error || timeout || (peer_in.request && !req_seen_q)
			|| (done && count_q == 16'hffff)) begin
			ready_q <= 1'b1;
		end else if (start) begin
			ready_q <= 1'b0;
		end
	end

	// Edge memory of the peer request so that a start can clear ready after it.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			req_seen_q <= 1'b0;
		end else begin
			req_seen_q <= peer_in.request;
		end
	end

	// peer request, direction, mode: plain software bits.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			diag_q <= 1'b0;
			allow_q <= 1'b0;
			ext_hi_q <= 1'b0;
			ext_lo_q <= 1'b0;
			req_out_q <= 1'b0;
			dir_q <= 1'b0;
			mode_q <= 1'b0;
		end else if (wr_st) begin
			diag_q <= reg_req.wdata[BIT_DIAG];
			allow_q <= reg_req.wdata[BIT_IRQ_ALLOW];
			ext_hi_q <= reg_req.wdata[BIT_EXT_HI];
			ext_lo_q <= reg_req.wdata[BIT_EXT_LO];
			req_out_q <= reg_req.wdata[BIT_PREQ_OUT];
			dir_q <= reg_req.wdata[BIT_DIR_OUT];
			mode_q <= reg_req.wdata[BIT_MODE_OUT];
		end
	end

	// start with cycle launches locally; peer request pulses set it.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cycle_q <= 1'b0;
		end else if (peer_in.cycle_req) begin
			cycle_q <= 1'b1;
		end else if (launch) begin
			cycle_q <= 1'b0;
		end else if (wr_st) begin
			cycle_q <= reg_req.wdata[BIT_CYCLE];
		end
	end

	// start pulse to peer
	// Start without cycle asks the transmitting companion for its first cycle.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			go_peer_q <= 1'b0;
			end_q <= 1'b0;
		end else begin
			go_peer_q <= start && !reg_req.wdata[BIT_CYCLE];
			end_q <= done; // The last word still needs its paired cycle.
		end
	end

	// end of each answered local cycle requests the peer's paired cycle.
	always_comb begin
		peer_out.request = req_out_q;
		peer_out.direction = dir_q;
		peer_out.mode = mode_q;
		peer_out.alert = req_out_q && !go_cycle_q;
		peer_out.cycle_req = go_peer_q || end_q;
	end

	// Rising edge memory of the outgoing request for the alert pulse.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			go_cycle_q <= 1'b0;
		end else begin
			go_cycle_q <= req_out_q;
		end
	end

	// sources feed the request when allowed.
	assign irq = allow_q && (error || ready_q || peer_in.request);

	// Read data register.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= WORD_RESET;
		end else if (reg_req.rd) begin
			case (reg_req.sel)
				SEL_COUNTER: reg_rdata <= count_q;
				SEL_POINTER: reg_rdata <= ptr_q;
				// live alert, mirrors, start reads zero.
				SEL_STATUS: reg_rdata <= {error, nex_q, peer_in.alert, diag_q,
					peer_in.request, peer_in.direction, peer_in.mode, cycle_q,
					ready_q, allow_q, ext_hi_q, ext_lo_q, req_out_q, dir_q, mode_q, 1'b0};
				default: reg_rdata <= WORD_RESET;
			endcase
		end
	end

	// Outgoing words read from local memory.
	word_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(done && !dir_q),
		.in_ready(tx_fifo_ready),
		.in_data(bus_rdata),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(tx_data)
	);

	// Incoming words to be written to local memory.
	word_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(rx_valid),
		.in_ready(rx_ready),
		.in_data(rx_data),
		.out_valid(rx_fifo_valid),
		.out_ready(done && dir_q),
		.out_data(rx_fifo_data)
	);

	// Cycle begin: master sync low, then high in the next cycle.
	sequence s_cycle_begin;
		!bus_msync ##1 bus_msync;
	endsequence

	// Helper for the reply bound: cycles of master sync without a reply, saturating.
	always_ff @(posedge clk) begin
		if (!rst_n || !bus_msync || bus_ssync) begin
			age_q <= 17'h00000;
		end else if (age_q != 17'h1ffff) begin
			age_q <= age_q + 17'h00001;
		end
	end

	a_nex_timeout: assert property (@(posedge clk) disable iff (!rst_n)
		age_q == 17'(TIMEOUT_CYC) |-> nex_q && !bus_msync)
		else $error("Master sync reached the timeout without the flag.");
	// cycles start only with ready clear
	a_launch_ready: assert property (@(posedge clk) disable iff (!rst_n)
		s_cycle_begin |-> !$past(ready_q))
		else $error("Bus cycle began although ready was set.");
	a_ready_block: assert property (@(posedge clk) disable iff (!rst_n)
		ready_q && state_q == ST_IDLE |=> !bus_msync)
		else $error("Bus cycle began while ready was set.");
	a_ptr_even: assert property (@(posedge clk) disable iff (!rst_n)
		!ptr_q[0])
		else $error("Pointer low bit is not zero.");
	a_error_ready: assert property (@(posedge clk) disable iff (!rst_n)
		error |=> ready_q)
		else $error("Error did not set ready.");
	a_ptr_step: assert property (@(posedge clk) disable iff (!rst_n)
		done && !wr_ptr |=> ptr_q == $past(ptr_q) + POINTER_STEP)
		else $error("Pointer did not advance by two.");
	a_cnt_step: assert property (@(posedge clk) disable iff (!rst_n)
		done && !wr_cnt |=> count_q == $past(count_q) + 16'h0001)
		else $error("Counter did not step after a cycle.");
	a_nex_no_set: assert property (@(posedge clk) disable iff (!rst_n)
		!nex_q && !timeout |=> !nex_q)
		else $error("Missing memory flag set without a timeout.");
	a_irq_gate: assert property (@(posedge clk) disable iff (!rst_n)
		!allow_q |-> !irq)
		else $error("Interrupt raised while not allowed.");
	a_cycle_clear: assert property (@(posedge clk) disable iff (!rst_n)
		launch && !peer_in.cycle_req |=> !cycle_q)
		else $error("Cycle flag not cleared when the cycle began.");
endmodule
`default_nettype wire

/* File: core/link_regs_pkg.sv */
// Purpose: Shared constants and carriers for the interprocessor DMA link registers.
// Assumes: 200 MHz clock, 16-bit register words.
// Notes: Register selects are small indices on the local register port.
package link_regs_pkg;

	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned NEX_TIMEOUT_NS = 20000;
	localparam int unsigned NEX_TIMEOUT_CYC = (NEX_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;

	localparam logic [1:0] SEL_COUNTER = 2'h0;
	localparam logic [1:0] SEL_POINTER = 2'h1;
	localparam logic [1:0] SEL_STATUS = 2'h2;

	localparam int BIT_ERROR = 15;
	localparam int BIT_NEX = 14;
	localparam int BIT_ALERT = 13;
	localparam int BIT_DIAG = 12;
	localparam int BIT_PREQ_IN = 11;
	localparam int BIT_PDIR_IN = 10;
	localparam int BIT_PMODE_IN = 9;
	localparam int BIT_CYCLE = 8;
	localparam int BIT_READY = 7;
	localparam int BIT_IRQ_ALLOW = 6;
	localparam int BIT_EXT_HI = 5;
	localparam int BIT_EXT_LO = 4;
	localparam int BIT_PREQ_OUT = 3;
	localparam int BIT_DIR_OUT = 2;
	localparam int BIT_MODE_OUT = 1;
	localparam int BIT_START = 0;

	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [15:0] POINTER_STEP = 16'h0002;

	// Cross-coupled link signals in one direction.
	typedef struct packed {
		logic request;
		logic direction;
		logic mode;
		logic alert;
		logic cycle_req;
	} link_type;

	// Local register port request.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [1:0] sel;
		logic [15:0] wdata;
	} reg_req_type;

endpackage

/* File: core/word_fifo.sv */
// Purpose: Parameterised valid/ready FIFO for link data words.
// Assumes: One clock, synchronous active-low reset.
// Notes: Full and empty are exact; depth must be a power of two.
`timescale 1ns/100ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Fill side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic push;
	logic pop;

	// Refuse depths the pointer arithmetic cannot serve.
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("word_fifo depth must be a power of two of at least two.");
	end

	// Handshake terms.
	assign in_ready = (wr_q - rd_q) != (AW + 1)'(DEPTH);
	assign out_valid = wr_q != rd_q;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rd_q[AW-1:0]];

	// Storage write.
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data;
		end
	end

	// Pointers.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: testbench/peer_model.sv */
// Purpose: Companion-side model: twin link levels and pulses, plus the local memory slave.
// Assumes: Peer signals are synchronous to clk; memory answers three cycles after master sync.
// Notes: The bench sets lvl and absent and calls the pulse tasks.
`timescale 1ns/100ps
`default_nettype none
module peer_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Link to and from the block.
	input wire link_regs_pkg::link_type peer_out,
	output link_regs_pkg::link_type peer_in,
	// Memory slave on the local bus.
	input wire logic bus_msync,
	input wire logic bus_write,
	input wire logic [17:0] bus_addr,
	input wire logic [15:0] bus_wdata,
	output logic bus_ssync,
	output logic [15:0] bus_rdata
);
	import link_regs_pkg::*;

	logic [2:0] lvl = 3'h0;
	logic absent = 1'b0;
	logic alert_q = 1'b0;
	logic cyc_q = 1'b0;
	logic msync_q = 1'b0;
	logic [1:0] wait_q = 2'h0;
	logic [17:0] last_addr = 18'h0;
	logic last_wr = 1'b0;
	logic [15:0] last_w = 16'h0;
	int ncyc = 0;
	int ncr = 0;
	int nal = 0;

	assign peer_in = '{request: lvl[2], direction: lvl[1], mode: lvl[0], alert: alert_q,
		cycle_req: cyc_q};

	// Holds the alert pulse for n cycles, as the twin does when its outgoing request rises.
	task automatic alert_pulse(input int n);
		@(posedge clk);
		#1 alert_q = 1'b1;
		repeat (n) @(posedge clk);
		#1 alert_q = 1'b0;
	endtask

	// One-cycle request for a local bus cycle.
	task automatic cyc_pulse;
		@(posedge clk);
		#1 cyc_q = 1'b1;
		@(posedge clk);
		#1 cyc_q = 1'b0;
	endtask

	// Counts cycle request and alert pulses sent across the link.
	always @(posedge clk) begin
		if (peer_out.cycle_req === 1'b1) begin
			ncr <= ncr + 1;
		end
		if (peer_out.alert === 1'b1) begin
			nal <= nal + 1;
		end
	end

	always @(posedge clk) begin
		msync_q <= bus_msync;
		bus_rdata <= ~bus_rdata;
		if (!rst_n || !bus_msync) begin
			wait_q <= 2'h0;
		end else if (!absent && wait_q != 2'h3) begin
			wait_q <= wait_q + 2'h1;
		end
		if (bus_msync && !msync_q) begin
			ncyc <= ncyc + 1;
			last_addr <= bus_addr;
			last_wr <= bus_write;
		end
		bus_ssync <= rst_n && bus_msync && !absent && wait_q >= 2'h2;
		if (rst_n && bus_msync && !absent && wait_q >= 2'h2) begin
			bus_rdata <= bus_addr[15:0] ^ 16'h5a5a;
			if (bus_write) begin
				last_w <= bus_wdata;
			end
		end
	end
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Purpose: Self-checking bench for the link register block through its register port.
// Assumes: Timeout shortened to 8 cycles; the peer model stands in for twin and memory.
// Notes: Scenarios run in order and rely on the state left by the one before.
`timescale 1ns/100ps
`default_nettype none
module tb;
	import link_regs_pkg::*;

`define CHK(nm, e, g) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		num_errors++; \
		$display("[ERR] %s expected %h seen %h", nm, e, g); \
	end \
end

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	reg_req_type rq = '0;
	logic [15:0] reg_rdata;
	link_type peer_in;
	link_type peer_out;
	logic bus_msync;
	logic bus_write;
	logic bus_ssync;
	logic irq;
	logic [17:0] bus_addr;
	logic [15:0] bus_rdata;
	logic [15:0] bus_wdata;
	logic tx_valid;
	logic tx_ready = 1'b0;
	logic [15:0] tx_data;
	logic rx_valid = 1'b0;
	logic rx_ready;
	logic [15:0] rx_data = 16'hc3a5;
	int num_errors = 0;
	int cmp_count = 0;
	int cyc_cnt = 0;
	int n;
	int m;

	interprocessor_dma_link_regs #(.TIMEOUT_CYC(8), .FIFO_DEPTH(16)) dut (.clk(clk),
		.rst_n(rst_n), .reg_req(rq), .reg_rdata(reg_rdata), .peer_in(peer_in),
		.peer_out(peer_out), .bus_msync(bus_msync), .bus_write(bus_write),
		.bus_addr(bus_addr), .bus_ssync(bus_ssync), .bus_rdata(bus_rdata),
		.bus_wdata(bus_wdata), .irq(irq), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));

	peer_model peer (.clk(clk), .rst_n(rst_n), .peer_out(peer_out), .peer_in(peer_in),
		.bus_msync(bus_msync), .bus_write(bus_write), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_ssync(bus_ssync), .bus_rdata(bus_rdata));

	// Free-running 200 MHz clock.
	initial begin
		forever #2.5 clk = ~clk;
	end

	// Prints the counts and the verdict, then stops.
	task automatic end_sim;
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Cuts a hang short well beyond the expected run length.
	always @(posedge clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 3000) begin
			num_errors++;
			end_sim();
		end
	end

	// One-cycle register write.
	task automatic wr(input logic [1:0] s, input logic [15:0] d);
		@(posedge clk);
		#1 rq = '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
		@(posedge clk);
		#1 rq = '0;
	endtask

	// One-cycle register read, compared under a mask once the data has landed.
	task automatic rd(input logic [1:0] s, input logic [15:0] mk, input logic [15:0] e,
		input string nm);
		@(posedge clk);
		#1 rq = '{wr: 1'b0, rd: 1'b1, sel: s, wdata: 16'h0};
		@(posedge clk);
		#1 rq = '0;
		@(posedge clk);
		#1;
		`CHK(nm, e, reg_rdata & mk)
	endtask

	// Waits, bounded, for one bus cycle to start and end.
	task automatic wait_cyc;
		int i;
		i = 0;
		while (bus_msync !== 1'b1 && i < 20) begin
			@(posedge clk);
			#1;
			i++;
		end
		while (bus_msync !== 1'b0 && i < 40) begin
			@(posedge clk);
			#1;
			i++;
		end
		`CHK("bus cycle ends", 1'b1, i < 40)
		repeat (3) @(posedge clk);
		#1;
	endtask

	// Main sequence of scenarios.
	initial begin
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		rd(SEL_STATUS, 16'hffff, 16'h0080, "status reset");
		`CHK("irq idle", 1'b0, irq)
		wr(SEL_STATUS, 16'h507e);
		rd(SEL_STATUS, 16'hffff, 16'h10fe, "status rw");
		`CHK("irq ready", 1'b1, irq)
		`CHK("peer levels", 3'h7, {peer_out.request, peer_out.direction, peer_out.mode})
		wr(SEL_STATUS, 16'h0000);
		peer.lvl = 3'h7;
		rd(SEL_STATUS, 16'h0e00, 16'h0e00, "mirrors");
		peer.lvl = 3'h0;
		fork
			peer.alert_pulse(12);
			begin
				repeat (3) @(posedge clk);
				rd(SEL_STATUS, 16'ha000, 16'ha000, "alert on");
			end
		join
		rd(SEL_STATUS, 16'ha000, 16'h0000, "alert off");
		n = peer.ncyc;
		peer.cyc_pulse();
		rd(SEL_STATUS, 16'h0180, 16'h0180, "peer cycle");
		`CHK("ready blocks", n, peer.ncyc)
		wr(SEL_STATUS, 16'h0000);
		wr(SEL_COUNTER, 16'hffff);
		wr(SEL_POINTER, 16'h0101);
		rd(SEL_POINTER, 16'hffff, 16'h0100, "pointer lsb");
		n = peer.ncr;
		wr(SEL_STATUS, 16'h0121);
		wait_cyc();
		`CHK("read addr", 18'h20100, peer.last_addr)
		`CHK("read kind", 1'b0, peer.last_wr)
		`CHK("tx word", 17'h15b5a, {tx_valid, tx_data})
		tx_ready = 1'b1;
		@(posedge clk);
		#1 tx_ready = 1'b0;
		rd(SEL_COUNTER, 16'hffff, 16'h0000, "counter step");
		rd(SEL_POINTER, 16'hffff, 16'h0102, "pointer step");
		rd(SEL_STATUS, 16'h8180, 16'h0080, "overflow ready");
		`CHK("end cycle pulse", n + 1, peer.ncr)
		`CHK("rx ready", 1'b1, rx_ready)
		rx_valid = 1'b1;
		@(posedge clk);
		#1 rx_valid = 1'b0;
		wr(SEL_COUNTER, 16'hffff);
		wr(SEL_POINTER, 16'h0400);
		wr(SEL_STATUS, 16'h0105);
		wait_cyc();
		`CHK("write word", 17'h1c3a5, {peer.last_wr, peer.last_w})
		`CHK("write addr", 18'h00400, peer.last_addr)
		peer.absent = 1'b1;
		wr(SEL_COUNTER, 16'hffff);
		wr(SEL_POINTER, 16'h0200);
		wr(SEL_STATUS, 16'h0141);
		wait_cyc();
		rd(SEL_STATUS, 16'hc080, 16'hc080, "missing memory");
		`CHK("irq error", 1'b1, irq)
		peer.absent = 1'b0;
		wr(SEL_STATUS, 16'h0000);
		rd(SEL_STATUS, 16'hc000, 16'h0000, "missing clear");
		wr(SEL_COUNTER, 16'hffff);
		wr(SEL_POINTER, 16'hfffe);
		wr(SEL_STATUS, 16'h0101);
		wait_cyc();
		rd(SEL_STATUS, 16'h8080, 16'h8080, "wrap error");
		rd(SEL_POINTER, 16'hffff, 16'h0000, "wrap value");
		wr(SEL_POINTER, 16'h0010);
		rd(SEL_STATUS, 16'h8000, 16'h0000, "reload clear");
		n = peer.ncr;
		m = peer.ncyc;
		wr(SEL_STATUS, 16'h0001);
		repeat (4) @(posedge clk);
		`CHK("start alone pulse", n + 1, peer.ncr)
		`CHK("start alone local", m, peer.ncyc)
		rd(SEL_STATUS, 16'h0081, 16'h0000, "start clears ready");
		m = peer.nal;
		wr(SEL_STATUS, 16'h517e);
		rd(SEL_STATUS, 16'h517e, 16'h117e, "status set");
		`CHK("irq quiet", 1'b0, irq)
		`CHK("alert pulse", m + 1, peer.nal)
		// System clear in mid-run must drop every software bit.
		@(posedge clk);
		#1 rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		rd(SEL_STATUS, 16'hffff, 16'h0080, "status clear");
		`CHK("peer clear", 3'h0, {peer_out.request, peer_out.direction, peer_out.mode})
		end_sim();
	end
endmodule
`default_nettype wire
